/* File: rtl/pdm_ctrl.sv */
// power-down mode controller: level select, go bit, wake handling
// assumes the cpu side writes through plain strobes on this clock
// wake sources are synchronous, active high, one cycle or longer
// hardware wake stands for the reset pin seen as a plain level
// go is seen one edge after its write and the state enters sleep on
// the next, so sleeping rises two edges after the go write edge
// outputs are registered; sleeping and the regulator enable change with the state, level and go copies lag one cycle
// writes while entering or asleep are dropped: the cpu is halted then
// the sleep timer is outside this block; only its interrupt comes in
// regulator output is an enable, high keeps the digital supply on
// no register bus here: level and go arrive as write strobes
`timescale 1ns/1ps
module pdm_ctrl
   import pdm_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // control writes
   input wire logic level_wr,
   input wire logic [PDM_LEVEL_W-1:0] level_wdata,
   input wire logic go_wr,
   input wire logic go_wdata,
   // wake sources
   input wire logic hw_wake,
   input wire logic timer_irq,
   input wire logic ext_irq,
   // status and power controls
   output logic [PDM_LEVEL_W-1:0] power_level_select,
   output logic power_down_go,
   output logic sleeping,
   output logic digital_reg_on,
   output logic reconfig_needed,
   output logic wake_pulse
);
   // fsm state
   pdm_state_t state_r;
   pdm_state_t state_nxt;
   // written level and go bit, as software sees them
   logic [PDM_LEVEL_W-1:0] level_r;
   logic go_r;
   // level frozen at entry; picks the wake set while asleep
   logic [PDM_LEVEL_W-1:0] active_r;
   // qualified wake and the two transitions used by several outputs
   logic wake;
   logic entering_sleep;
   logic waking;

   // levels that drop the digital regulator; shared by the regulator
   // output and the reconfiguration flag so both agree
   function automatic logic reg_off_level(logic [PDM_LEVEL_W-1:0] lvl);
      return (lvl == PDM_MEDIUM) || (lvl == PDM_DEEP);
   endfunction

   // any code but active asks for a sleep level
   function automatic logic sleep_level(logic [PDM_LEVEL_W-1:0] lvl);
      return lvl != PDM_ACTIVE;
   endfunction

   pdm_wake_sel u_wake (
      .level(pdm_level_t'(active_r)),
      .hw_wake(hw_wake),
      .timer_irq(timer_irq),
      .ext_irq(ext_irq),
      .wake(wake)
   );

   // wake set of the frozen level
   assign waking = (state_r == ST_SLEEP) && wake;
   assign entering_sleep = (state_r == ST_ENTER) && (state_nxt == ST_SLEEP);

   // level select field
   // cleared on wake so a read after waking shows active
   // writes outside run are dropped: the cpu is halted then
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         level_r <= PDM_LEVEL_RST;
      end else if (state_r == ST_WAKE) begin
         level_r <= PDM_LEVEL_RST;
      end else if (level_wr && state_r == ST_RUN) begin
         level_r <= level_wdata;
      end
   end

   // wake clears go
   // a go written with level zero clears itself via the wake state
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         go_r <= PDM_GO_RST;
      end else if (state_r == ST_WAKE) begin
         go_r <= PDM_GO_RST;
      end else if (go_wr && state_r == ST_RUN) begin
         go_r <= go_wdata;
      end
   end

   // run waits for go; enter freezes the level for one cycle
   // sleep waits for a wake allowed by the frozen level
   // wake spends one cycle clearing go and level before run
   // a go with level zero passes through wake so go self-clears
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN: begin
            if (go_r && sleep_level(level_r)) begin
               state_nxt = ST_ENTER;
            end else if (go_r) begin
               // level zero: nothing to enter, just clear go
               state_nxt = ST_WAKE;
            end
         end
         // one settle cycle so the level lands in active_r
         ST_ENTER: state_nxt = ST_SLEEP;
         ST_SLEEP: begin
            if (wake) begin
               state_nxt = ST_WAKE;
            end
         end
         ST_WAKE: state_nxt = ST_RUN;
         default: state_nxt = ST_RUN;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_r <= ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // level latched at entry so a late write cannot change wake set
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         active_r <= PDM_LEVEL_RST;
      end else if (state_r == ST_ENTER) begin
         active_r <= level_r;
      end else if (state_r == ST_WAKE) begin
         active_r <= PDM_LEVEL_RST;
      end
   end

   // regulator off deeper
   // dropped on the entry edge so it falls as sleeping rises
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         digital_reg_on <= PDM_REG_ON;
      end else if (entering_sleep) begin
         digital_reg_on <= !reg_off_level(level_r);
      end else if (state_nxt == ST_WAKE) begin
         digital_reg_on <= PDM_REG_ON;
      end
   end

   // reconfiguration after wake
   // flag stays until software rewrites the level select
   // wake beats a level write in the same cycle so no warning is lost
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reconfig_needed <= PDM_FLAG_RST;
      end else if (waking && reg_off_level(active_r)) begin
         reconfig_needed <= 1'b1;
      end else if (level_wr) begin
         reconfig_needed <= PDM_FLAG_RST;
      end
   end

   // level select seen by software
   // copy lags the field by one cycle; cheaper than a bypass mux
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         power_level_select <= PDM_LEVEL_RST;
      end else begin
         power_level_select <= level_r;
      end
   end

   // go bit seen by software
   // reads back one until the wake has been taken
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         power_down_go <= PDM_GO_RST;
      end else begin
         power_down_go <= go_r;
      end
   end

   // sleep status from the next state so it rises with the regulator drop
   // high only in the sleep state, not while entering
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sleeping <= PDM_FLAG_RST;
      end else begin
         sleeping <= (state_nxt == ST_SLEEP);
      end
   end

   // one pulse per wake
   // a wake held for several cycles still gives one pulse, since the
   // state has left sleep by the second cycle
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wake_pulse <= PDM_FLAG_RST;
      end else begin
         wake_pulse <= waking;
      end
   end
endmodule

/* File: rtl/pdm_pkg.sv */
// package for the power-down mode controller
// assumes one 100 MHz system clock and a synchronous active-high reset
package pdm_pkg;
   localparam int PDM_LEVEL_W = 2;
   typedef enum logic [1:0] {
      PDM_ACTIVE = 2'h0,
      PDM_LIGHT = 2'h1,
      PDM_MEDIUM = 2'h2,
      PDM_DEEP = 2'h3
   } pdm_level_t;
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_ENTER = 4'h2,
      ST_SLEEP = 4'h4,
      ST_WAKE = 4'h8
   } pdm_state_t;
   localparam logic [PDM_LEVEL_W-1:0] PDM_LEVEL_RST = 2'h0;
   localparam logic PDM_GO_RST = 1'b0;
   localparam logic PDM_REG_ON = 1'b1;
   localparam logic PDM_FLAG_RST = 1'b0;
endpackage

/* File: rtl/pdm_wake_sel.sv */
// wake source qualifier, picks the sources allowed for a sleep level
// assumes sources are single-clock synchronous levels or pulses
`timescale 1ns/1ps
module pdm_wake_sel
   import pdm_pkg::*;
(
   // level in force
   input wire pdm_level_t level,
   // wake sources
   input wire logic hw_wake,
   input wire logic timer_irq,
   input wire logic ext_irq,
   // result
   output logic wake
);
   always_comb begin
      case (level)
         PDM_LIGHT: wake = hw_wake | timer_irq | ext_irq;
         PDM_MEDIUM: wake = hw_wake | timer_irq | ext_irq;
         PDM_DEEP: wake = hw_wake | ext_irq;
         default: wake = 1'b0;
      endcase
   end
endmodule

/* File: tb/pdm_ctrl_chk.sv */
// port assertions for the power-down controller
// assumes a bind onto pdm_ctrl from the bench top
`timescale 1ns/1ps
module pdm_ctrl_chk
   import pdm_pkg::*;
(
   // clock, reset, inputs
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic go_wr,
   input wire logic hw_wake,
   input wire logic timer_irq,
   input wire logic ext_irq,
   // outputs
   input wire logic [PDM_LEVEL_W-1:0] power_level_select,
   input wire logic power_down_go,
   input wire logic sleeping,
   input wire logic digital_reg_on,
   input wire logic wake_pulse
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   lvl_nonzero_a: assert property (sleeping |-> power_level_select != 2'h0)
      else $error("sleep at level zero");
   go_start_a: assert property ($rose(sleeping) |-> $past(go_wr, 3))
      else $error("sleep without go");
   reg_light_a: assert property (sleeping && power_level_select == 2'h1
      |-> digital_reg_on)
      else $error("regulator off in light");
   reg_off_a: assert property (sleeping && power_level_select[1]
      |-> !digital_reg_on)
      else $error("regulator on in deeper level");
   deep_timer_a: assert property (sleeping && power_level_select == 2'h3
      && timer_irq && !ext_irq && !hw_wake |=> sleeping)
      else $error("timer woke deep level");
   wake_src_a: assert property (sleeping && (ext_irq || hw_wake)
      |-> ##[1:2] wake_pulse)
      else $error("no wake");
   wake_edge_a: assert property (wake_pulse
      |-> $past(sleeping) && !sleeping)
      else $error("stray wake pulse");
   go_clear_a: assert property ($fell(sleeping) |-> ##[1:3]
      !power_down_go && power_level_select == 2'h0)
      else $error("go not cleared");
   cover property (sleeping && power_level_select == 2'h1);
   cover property (sleeping && power_level_select == 2'h2);
   cover property (sleeping && power_level_select == 2'h3);
endmodule

/* File: tb/test_pdm_ctrl.sv */
// bench for the power-down controller, each level in turn
// assumes pdm_ctrl on a 100 MHz clock, checker bound below
`timescale 1ns/1ps
module test_pdm_ctrl;
   logic clock = 0, sys_rst = 1, level_wr = 0, go_wr = 0, go_wdata = 0;
   logic hw_wake = 0, timer_irq = 0, ext_irq = 0;
   logic [1:0] level_wdata = 2'h0, power_level_select;
   logic power_down_go, sleeping, digital_reg_on, reconfig_needed;
   logic wake_pulse;
   int n_fail = 0, checks = 0;
   pdm_ctrl pdm_ctrl_i (
      .clock(clock),
      .sys_rst(sys_rst),
      .level_wr(level_wr),
      .level_wdata(level_wdata),
      .go_wr(go_wr),
      .go_wdata(go_wdata),
      .hw_wake(hw_wake),
      .timer_irq(timer_irq),
      .ext_irq(ext_irq),
      .power_level_select(power_level_select),
      .power_down_go(power_down_go),
      .sleeping(sleeping),
      .digital_reg_on(digital_reg_on),
      .reconfig_needed(reconfig_needed),
      .wake_pulse(wake_pulse)
   );
   initial forever #5 clock = ~clock;
   task automatic step(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(logic [1:0] got, logic [1:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
   endtask
   task automatic start(logic [1:0] v);
      level_wdata = v;
      pulse(level_wr);
      go_wdata = 1'b1;
      pulse(go_wr);
      step(3);
   endtask
   task automatic sleep_lvl(logic [1:0] v);
      start(v);
      chk({sleeping, digital_reg_on}, {1'b1, v == 2'h1});
      case (v)
         2'h1: pulse(timer_irq);
         2'h2: pulse(hw_wake);
         default: begin
            pulse(timer_irq);
            step(3);
            chk({1'b0, sleeping}, 2'h1);
            pulse(ext_irq);
         end
      endcase
      chk({wake_pulse, sleeping}, 2'h2);
      step(4);
      chk({sleeping, reconfig_needed}, {1'b0, v != 2'h1});
      chk({power_down_go, wake_pulse}, 2'h0);
      chk(power_level_select, 2'h0);
   endtask
   task automatic reset_in_sleep();
      start(2'h3);
      sys_rst = 1'b1;
      step(2);
      sys_rst = 1'b0;
      chk({sleeping, digital_reg_on}, 2'h1);
      chk({power_down_go, wake_pulse}, 2'h0);
      chk(power_level_select, 2'h0);
      start(2'h1);
      chk({sleeping, digital_reg_on}, 2'h3);
      pulse(ext_irq);
      chk({wake_pulse, sleeping}, 2'h2);
      step(4);
   endtask
   task automatic print_verdict();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      step(6);
      sys_rst = 1'b0;
      start(2'h0);
      chk({sleeping, power_down_go}, 2'h0);
      for (int v = 1; v < 4; v++) sleep_lvl(2'(v));
      reset_in_sleep();
      print_verdict();
   end
   // watchdog, run needs well under 200 cycles
   initial begin
      #20000;
      n_fail++;
      print_verdict();
   end
endmodule
bind pdm_ctrl pdm_ctrl_chk pdm_ctrl_chk_i (
   .clock(clock),
   .sys_rst(sys_rst),
   .go_wr(go_wr),
   .hw_wake(hw_wake),
   .timer_irq(timer_irq),
   .ext_irq(ext_irq),
   .power_level_select(power_level_select),
   .power_down_go(power_down_go),
   .sleeping(sleeping),
   .digital_reg_on(digital_reg_on),
   .wake_pulse(wake_pulse)
);
